// File: hw/asb_buf_ram.sv
/*
  Buffer RAM of the sequencer: 32 bytes, one port, registered read data.
  Assumes the caller arbitrates the single port between its users.
*/
`timescale 1ns/10ps
module asb_buf_ram (
  // clock and freeze
  input  wire logic                         mclk,
  input  wire logic                         ce,
  // single access port
  input  wire logic                         we,
  input  wire logic [asb_pkg::IDX_W-1:0]    addr,
  input  wire logic [asb_pkg::DATA_W-1:0]   wrData,
  output logic      [asb_pkg::DATA_W-1:0]   rdData
);

  logic [asb_pkg::DATA_W-1:0] mem [asb_pkg::BUF_DEPTH];

  // ==========================================================================
  // storage; no reset so it maps onto plain RAM cells
  always_ff @(posedge mclk) begin
    if (ce) begin
      if (we) begin
        mem[addr] <= wrData;
      end
      rdData <= mem[addr];
    end
  end

endmodule

// File: hw/asb_link.sv
/*
  Link-side byte shifter, clocked by the serial clock of the peer.
  Assumes the sequencer holds txByte steady from before a start toggle until
  the done toggle returns, and that the serial clock runs while bytes move.
*/
`timescale 1ns/10ps
module asb_link (
  // link clock and reset
  input  wire logic                         sclk,
  input  wire logic                         nrst,
  // sequencer side (system clock domain)
  input  wire logic                         startTgl,
  input  wire logic [asb_pkg::DATA_W-1:0]   txByte,
  output logic                              doneTgl,
  output logic      [asb_pkg::DATA_W-1:0]   rxByte,
  // serial pins
  input  wire logic                         serialIn,
  output logic                              serialOut
);

  logic                       startS1_r, startS2_r, startSeen_r, startSeen_nxt;
  logic                       busy_r, busy_nxt;
  logic [3:0]                 cnt_r, cnt_nxt;
  logic [asb_pkg::DATA_W-1:0] sh_r, sh_nxt, rxByte_nxt;
  logic                       doneTgl_nxt, serialOut_nxt;

  // ==========================================================================
  // shift engine: msb first, out changes and in is sampled on the rising edge
  always_comb begin
    startSeen_nxt = startSeen_r;
    busy_nxt      = busy_r;
    cnt_nxt       = cnt_r;
    sh_nxt        = sh_r;
    rxByte_nxt    = rxByte;
    doneTgl_nxt   = doneTgl;
    serialOut_nxt = serialOut;
    if (!busy_r) begin
      serialOut_nxt = 1'b0;
      if (startS2_r != startSeen_r) begin
        startSeen_nxt = startS2_r;
        busy_nxt      = 1'b1;
        cnt_nxt       = 4'h0;
        sh_nxt        = txByte;
        serialOut_nxt = txByte[asb_pkg::DATA_W-1];
      end
    end else begin
      sh_nxt        = {sh_r[asb_pkg::DATA_W-2:0], serialIn};
      serialOut_nxt = sh_r[asb_pkg::DATA_W-2];
      cnt_nxt       = cnt_r + 4'h1;
      if (cnt_r == asb_pkg::BIT_LAST) begin
        busy_nxt      = 1'b0;
        rxByte_nxt    = sh_nxt;
        doneTgl_nxt   = ~doneTgl;
        serialOut_nxt = 1'b0;
      end
    end
  end

  // registers; start toggle passes two flops before the engine reads it
  always_ff @(posedge sclk or negedge nrst) begin
    if (!nrst) begin
      startS1_r   <= 1'b0;
      startS2_r   <= 1'b0;
      startSeen_r <= 1'b0;
      busy_r      <= 1'b0;
      cnt_r       <= 4'h0;
      sh_r        <= 8'h00;
      rxByte      <= 8'h00;
      doneTgl     <= 1'b0;
      serialOut   <= 1'b0;
    end else begin
      startS1_r   <= startTgl;
      startS2_r   <= startS1_r;
      startSeen_r <= startSeen_nxt;
      busy_r      <= busy_nxt;
      cnt_r       <= cnt_nxt;
      sh_r        <= sh_nxt;
      rxByte      <= rxByte_nxt;
      doneTgl     <= doneTgl_nxt;
      serialOut   <= serialOut_nxt;
    end
  end

  // ==========================================================================
  // checks
  a_byte_eight: assert property (
    @(posedge sclk) disable iff (!nrst)
    $rose(busy_r) |-> busy_r [*8] ##1 !busy_r)
    else $error("link byte did not last eight clocks");

  a_idle_out_low: assert property (
    @(posedge sclk) disable iff (!nrst)
    $fell(busy_r) |-> !serialOut ##1 (busy_r || !serialOut))
    else $error("serial out not low after byte end");

endmodule

// File: hw/asb_pkg.sv
/*
  Package of the automatic serial buffer sequencer: buffer geometry, field
  widths, timing counts, carrier structs and the sequencer state type.
  Assumes every design file refers to it as asb_pkg::name, with no import.
*/
// Notes on behaviour
// - rx allow picks transmit/receive (one) or transmit-only (zero) when repeat is off
// - a shift register write only triggers; its data is never sent
// - each byte is copied from buffer at the index into the shifter, then sent
// - in transmit/receive mode each received byte goes to buffer at the index
// - index decrements after each byte except the one at index zero; run ends after index zero is sent
// - transfer active flag clears when the run ends
// - each serial transfer moves exactly eight bits
// - a shift register write starts nothing unless serial port on is set
// - basic modes set the done flag and raise the interrupt after the last byte
// - strobe and busy pins stay free; data-in pin free in transmit-only mode
// - a gap for buffer access is inserted between bytes
// - serial data out is low whenever the transfer active flag is clear
// - transmit/receive: store received byte, then decrement, then load next
// - transmit-only: decrement without storing, then load next
// - final received byte is stored before the done flag is set
// - repeat mode without receive reloads the start index and sends again, no flag
package asb_pkg;

  // ==========================================================================
  // buffer geometry
  localparam int          IDX_W     = 5;
  localparam int          DATA_W    = 8;
  localparam int          ADDR_W    = 16;
  localparam int          BUF_DEPTH = 32;
  localparam logic [15:0] BUF_BASE  = 16'hFAC0;
  localparam logic [15:0] BUF_TOP   = 16'hFADF;
  localparam logic [4:0]  IDX_ZERO  = 5'h00;
  localparam logic [4:0]  IDX_ONE   = 5'h01;

  // ==========================================================================
  // serial framing and gap timing
  localparam logic [3:0]  BITS_PER_BYTE = 4'h8;
  localparam logic [3:0]  BIT_LAST      = 4'h7;
  localparam int          GAP_W         = 12;
  localparam int          GAP_UNIT_LOG2 = 6;    // gap step is 2^6 system clocks
  localparam logic [11:0] GAP_ONE       = 12'h001;

  // ==========================================================================
  // carrier structs and the sequencer state type
  typedef struct packed {
    logic serialPortOn;
    logic autoTransferEnable;
  } asb_serial_mode_t;

  typedef struct packed {
    logic rxAllow;
    logic autoRepeatSelect;
  } asb_auto_ctrl_t;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_FETCH,
    ST_LOAD,
    ST_SHIFT,
    ST_STORE,
    ST_NEXT,
    ST_GAP
  } asb_state_t;

endpackage

// File: hw/asb_sequencer.sv
/*
  Automatic serial buffer sequencer: moves bytes between the buffer RAM and
  the link shifter under a down-counting index, with gap timing, repeat mode,
  suspend on port off, and a sticky transfer done flag.
  Assumes control bits come from software registers on the system clock and
  the serial clock arrives from the peer as a clock of its own.
*/
`timescale 1ns/10ps
module asb_sequencer (
  // system clock, reset, freeze
  input  wire logic                           mclk,
  input  wire logic                           nrst,
  input  wire logic                           ce,
  // link clock and serial pins
  input  wire logic                           sclk,
  input  wire logic                           serialIn,
  output logic                                serialOut,
  output logic                                serialInInUse,
  // control bits
  input  wire asb_pkg::asb_serial_mode_t      serialModeReg,
  input  wire asb_pkg::asb_auto_ctrl_t        autoCtrlReg,
  input  wire logic [asb_pkg::IDX_W-1:0]      byteGapSetting,
  input  wire logic                           shiftRegWrite,
  input  wire logic                           bufferIndexWrite,
  input  wire logic [asb_pkg::IDX_W-1:0]      bufferIndexIn,
  input  wire logic                           irqFlagClear,
  // status
  output logic      [asb_pkg::IDX_W-1:0]      bufferIndex,
  output logic                                transferActiveFlag,
  output logic                                transferDoneIrqFlag,
  output logic                                transferDoneInterrupt,
  // processor access to buffer RAM
  input  wire logic                           cpuRamReq,
  input  wire logic                           cpuRamWe,
  input  wire logic [asb_pkg::ADDR_W-1:0]     cpuRamAddr,
  input  wire logic [asb_pkg::DATA_W-1:0]     cpuRamWrData,
  output logic                                cpuRamReady,
  output logic      [asb_pkg::DATA_W-1:0]     cpuRamRdData
);

  asb_pkg::asb_state_t              state_r, state_nxt;
  logic [asb_pkg::IDX_W-1:0]        idx_nxt, startIdx_r, startIdx_nxt;
  logic                             trf_nxt, irq_nxt, intr_nxt;
  logic [asb_pkg::GAP_W-1:0]        gapCnt_r, gapCnt_nxt, gapLoad;
  logic [asb_pkg::DATA_W-1:0]       txByte_r, txByte_nxt;
  logic                             startTgl_r, startTgl_nxt;
  logic                             doneS1_r, doneS2_r, doneS3_r;
  logic                             doneEdge;
  logic [asb_pkg::DATA_W-1:0]       linkRxByte;
  logic                             linkDoneTgl;
  logic                             seqOwn, ramWe, cpuHit;
  logic [asb_pkg::IDX_W-1:0]        ramAddr;
  logic [asb_pkg::ADDR_W-1:0]       seqAddr, cpuOffset;
  logic [asb_pkg::DATA_W-1:0]       ramWrData, ramRdData;
  logic                             startOk;

  // ==========================================================================
  // buffer RAM port sharing
  // sequencer wins the port in its fetch and store cycles; the processor waits
  assign seqOwn    = (state_r == asb_pkg::ST_FETCH) || (state_r == asb_pkg::ST_STORE);
  assign seqAddr   = asb_pkg::BUF_BASE + {11'h000, bufferIndex};
  assign cpuOffset = cpuRamAddr - asb_pkg::BUF_BASE;
  assign cpuHit    = (cpuRamAddr >= asb_pkg::BUF_BASE) && (cpuRamAddr <= asb_pkg::BUF_TOP);
  assign cpuRamReady = !seqOwn;

  always_comb begin
    if (seqOwn) begin
      ramAddr   = seqAddr[asb_pkg::IDX_W-1:0];
      ramWe     = (state_r == asb_pkg::ST_STORE);
      ramWrData = linkRxByte;
    end else begin
      ramAddr   = cpuOffset[asb_pkg::IDX_W-1:0];
      ramWe     = cpuRamReq && cpuRamWe && cpuHit;
      ramWrData = cpuRamWrData;
    end
  end

  asb_buf_ram u_ram (
    .mclk   (mclk),
    .ce     (ce),
    .we     (ramWe),
    .addr   (ramAddr),
    .wrData (ramWrData),
    .rdData (ramRdData)
  );

  // processor read data straight from the registered RAM output
  assign cpuRamRdData = ramRdData;

  // ==========================================================================
  // link shifter in the serial clock domain
  asb_link u_link (
    .sclk      (sclk),
    .nrst      (nrst),
    .startTgl  (startTgl_r),
    .txByte    (txByte_r),
    .doneTgl   (linkDoneTgl),
    .rxByte    (linkRxByte),
    .serialIn  (serialIn),
    .serialOut (serialOut)
  );

  // done toggle crosses by two flops; the edge looks only at the second and third
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      doneS1_r <= 1'b0;
      doneS2_r <= 1'b0;
      doneS3_r <= 1'b0;
    end else if (ce) begin
      doneS1_r <= linkDoneTgl;
      doneS2_r <= doneS1_r;
      doneS3_r <= doneS2_r;
    end
  end
  assign doneEdge = doneS2_r ^ doneS3_r;

  // data-in pin is only claimed while receiving; strobe and busy never used
  assign serialInInUse = transferActiveFlag && autoCtrlReg.rxAllow;

  // ==========================================================================
  // sequencer
  // start needs port on and auto enable; written data is never looked at
  assign startOk = shiftRegWrite && serialModeReg.serialPortOn
                   && serialModeReg.autoTransferEnable;
  // gap length: (setting + 1) steps of 2^6 system clocks
  assign gapLoad = ({7'h00, byteGapSetting} + asb_pkg::GAP_ONE) << asb_pkg::GAP_UNIT_LOG2;

  always_comb begin
    state_nxt    = state_r;
    idx_nxt      = bufferIndex;
    startIdx_nxt = startIdx_r;
    trf_nxt      = transferActiveFlag;
    irq_nxt      = transferDoneIrqFlag && !irqFlagClear;
    intr_nxt     = 1'b0;
    gapCnt_nxt   = gapCnt_r;
    txByte_nxt   = txByte_r;
    startTgl_nxt = startTgl_r;
    case (state_r)
      asb_pkg::ST_IDLE: begin
        if (bufferIndexWrite) begin
          idx_nxt = bufferIndexIn;
        end
        if (startOk) begin
          trf_nxt      = 1'b1;
          startIdx_nxt = bufferIndex;
          state_nxt    = asb_pkg::ST_FETCH;
        end
      end
      asb_pkg::ST_FETCH: begin
        state_nxt = asb_pkg::ST_LOAD;
      end
      asb_pkg::ST_LOAD: begin
        txByte_nxt   = ramRdData;
        startTgl_nxt = ~startTgl_r;
        state_nxt    = asb_pkg::ST_SHIFT;
      end
      asb_pkg::ST_SHIFT: begin
        if (doneEdge) begin
          if (autoCtrlReg.rxAllow) begin
            state_nxt = asb_pkg::ST_STORE;
          end else begin
            state_nxt = asb_pkg::ST_NEXT;
          end
        end
      end
      asb_pkg::ST_STORE: begin
        state_nxt = asb_pkg::ST_NEXT;
      end
      asb_pkg::ST_NEXT: begin
        if (bufferIndex == asb_pkg::IDX_ZERO) begin
          if (autoCtrlReg.autoRepeatSelect && !autoCtrlReg.rxAllow) begin
            idx_nxt    = startIdx_r;
            gapCnt_nxt = gapLoad;
            state_nxt  = serialModeReg.serialPortOn ? asb_pkg::ST_GAP : asb_pkg::ST_IDLE;
            trf_nxt    = serialModeReg.serialPortOn;
          end else begin
            trf_nxt   = 1'b0;
            irq_nxt   = 1'b1;
            intr_nxt  = 1'b1;
            state_nxt = asb_pkg::ST_IDLE;
          end
        end else begin
          idx_nxt = bufferIndex - asb_pkg::IDX_ONE;
          if (serialModeReg.serialPortOn) begin
            gapCnt_nxt = gapLoad;
            state_nxt  = asb_pkg::ST_GAP;
          end else begin
            // suspend: remaining bytes resume on the next trigger
            trf_nxt   = 1'b0;
            state_nxt = asb_pkg::ST_IDLE;
          end
        end
      end
      asb_pkg::ST_GAP: begin
        gapCnt_nxt = gapCnt_r - asb_pkg::GAP_ONE;
        if (gapCnt_r == asb_pkg::GAP_ONE) begin
          state_nxt = asb_pkg::ST_FETCH;
        end
      end
      default: begin
        state_nxt = asb_pkg::ST_IDLE;
        trf_nxt   = 1'b0;
      end
    endcase
  end

  // registers of the sequencer
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      state_r               <= asb_pkg::ST_IDLE;
      bufferIndex           <= 5'h00;
      startIdx_r            <= 5'h00;
      transferActiveFlag    <= 1'b0;
      transferDoneIrqFlag   <= 1'b0;
      transferDoneInterrupt <= 1'b0;
      gapCnt_r              <= 12'h000;
      txByte_r              <= 8'h00;
      startTgl_r            <= 1'b0;
    end else if (ce) begin
      state_r               <= state_nxt;
      bufferIndex           <= idx_nxt;
      startIdx_r            <= startIdx_nxt;
      transferActiveFlag    <= trf_nxt;
      transferDoneIrqFlag   <= irq_nxt;
      transferDoneInterrupt <= intr_nxt;
      gapCnt_r              <= gapCnt_nxt;
      txByte_r              <= txByte_nxt;
      startTgl_r            <= startTgl_nxt;
    end
  end

  // ==========================================================================
  // checks
  a_start_gated: assert property (
    @(posedge mclk) disable iff (!nrst)
    (state_r == asb_pkg::ST_IDLE && shiftRegWrite && !serialModeReg.serialPortOn
     && !transferActiveFlag) |=> !transferActiveFlag)
    else $error("transfer started with serial port off");

  a_start_sets: assert property (
    @(posedge mclk) disable iff (!nrst)
    (state_r == asb_pkg::ST_IDLE && startOk && ce)
      |=> transferActiveFlag && state_r == asb_pkg::ST_FETCH)
    else $error("start trigger did not raise active flag");

  a_load_from_ram: assert property (
    @(posedge mclk) disable iff (!nrst)
    (state_r == asb_pkg::ST_LOAD && ce) |=> txByte_r == $past(ramRdData))
    else $error("shifter byte not taken from buffer");

  a_store_addr: assert property (
    @(posedge mclk) disable iff (!nrst)
    (state_r == asb_pkg::ST_STORE) |-> ramWe && ramAddr == bufferIndex
      && ramWrData == linkRxByte)
    else $error("received byte not written at index");

  a_tx_no_store: assert property (
    @(posedge mclk) disable iff (!nrst)
    (state_r == asb_pkg::ST_SHIFT && doneEdge && !autoCtrlReg.rxAllow && ce)
      |=> state_r == asb_pkg::ST_NEXT)
    else $error("transmit-only mode went to store");

  a_idx_dec: assert property (
    @(posedge mclk) disable iff (!nrst)
    (state_r == asb_pkg::ST_NEXT && bufferIndex != asb_pkg::IDX_ZERO && ce)
      |=> bufferIndex == $past(bufferIndex) - asb_pkg::IDX_ONE)
    else $error("index not decremented after byte");

  a_end_clears: assert property (
    @(posedge mclk) disable iff (!nrst)
    (state_r == asb_pkg::ST_NEXT && bufferIndex == asb_pkg::IDX_ZERO
     && !autoCtrlReg.autoRepeatSelect && ce)
      |=> !transferActiveFlag && transferDoneIrqFlag && transferDoneInterrupt)
    else $error("run end did not clear active or set done flag");

  a_irq_after_last: assert property (
    @(posedge mclk) disable iff (!nrst)
    $rose(transferDoneIrqFlag) |-> $past(state_r) == asb_pkg::ST_NEXT
      && $past(bufferIndex) == asb_pkg::IDX_ZERO)
    else $error("done flag set outside last byte");

  a_repeat_reload: assert property (
    @(posedge mclk) disable iff (!nrst)
    (state_r == asb_pkg::ST_NEXT && bufferIndex == asb_pkg::IDX_ZERO
     && autoCtrlReg.autoRepeatSelect && !autoCtrlReg.rxAllow && ce)
      |=> !$rose(transferDoneIrqFlag) && bufferIndex == $past(startIdx_r))
    else $error("repeat mode did not reload index");

  a_flag_set_wins: assert property (
    @(posedge mclk) disable iff (!nrst)
    $rose(transferDoneInterrupt) |-> transferDoneIrqFlag)
    else $error("done flag lost to clear");

  a_gap_min: assert property (
    @(posedge mclk) disable iff (!nrst)
    (state_r == asb_pkg::ST_GAP && $past(state_r) == asb_pkg::ST_NEXT)
      |-> gapCnt_r >= (asb_pkg::GAP_ONE << asb_pkg::GAP_UNIT_LOG2))
    else $error("byte gap shorter than one step");

endmodule

// File: verif/asb_sequencer_tb_top.sv
/*
  Bench of the buffer sequencer: buffer access tasks, runs in three modes.
  Assumes the peer model supplies the link clock while a run is active.
*/
`timescale 1ns/10ps
module asb_sequencer_tb_top;
  logic                     mclk = 1'b0;
  logic                     nrst = 1'b0;
  logic                     sclk, sIn, sOut, inUse, rxLvl;
  asb_pkg::asb_serial_mode_t mode;
  asb_pkg::asb_auto_ctrl_t   ac;
  logic [4:0]               gap, idxIn, idx;
  logic                     srw, idxW, clr, act, flag, irq, req, we, rdy, ce;
  logic [15:0]              addr;
  logic [7:0]               wd, rdData, rd;
  int                       bad_count = 0;
  int                       n_checks = 0;
  int                       cyc = 0;
  int                       irqs = 0;
  int                       actCyc = 0;

  always #20 mclk = ~mclk;

  asb_sequencer asb_sequencer_i (.mclk(mclk), .nrst(nrst), .ce(ce), .sclk(sclk),
    .serialIn(sIn), .serialOut(sOut), .serialInInUse(inUse), .serialModeReg(mode),
    .autoCtrlReg(ac), .byteGapSetting(gap), .shiftRegWrite(srw),
    .bufferIndexWrite(idxW), .bufferIndexIn(idxIn), .irqFlagClear(clr),
    .bufferIndex(idx), .transferActiveFlag(act), .transferDoneIrqFlag(flag),
    .transferDoneInterrupt(irq), .cpuRamReq(req), .cpuRamWe(we), .cpuRamAddr(addr),
    .cpuRamWrData(wd), .cpuRamReady(rdy), .cpuRamRdData(rdData));
  asb_serial_peer asb_serial_peer_i (.run(act | ~nrst), .rxLvl(rxLvl), .serialOut(sOut),
    .sclk(sclk), .serialIn(sIn));

  // ==========================================================
  // compare, access and control tasks
  task chk8(input logic [7:0] g, input logic [7:0] e);
    n_checks++;
    if (g !== e) begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task chk1(input logic g, input logic e);
    chk8({7'h00, g}, {7'h00, e});
  endtask
  task chkGot(input logic [7:0] e[$]);
    chk8(8'(asb_serial_peer_i.got.size()), 8'(e.size()));
    foreach (e[i]) chk8(asb_serial_peer_i.got[i], e[i]);
    asb_serial_peer_i.got.delete();
  endtask
  // request held until ready is sampled high; reads hold one edge more
  task ram(input logic w, input logic [4:0] a, input logic [7:0] d);
    @(posedge mclk) #2;
    req = 1'b1; we = w; addr = asb_pkg::BUF_BASE + 16'(a); wd = d;
    do @(posedge mclk); while (rdy !== 1'b1);
    if (!w) @(posedge mclk) rd = rdData;
    #2 req = 1'b0;
  endtask
  task pulse(input int which);
    @(posedge mclk) #2;
    if (which == 0) srw = 1'b1; else if (which == 1) idxW = 1'b1; else clr = 1'b1;
    @(posedge mclk) #2;
    {srw, idxW, clr} = 3'h0;
  endtask
  task waitIdle;
    while (act !== 1'b0) @(posedge mclk);
    #2;
  endtask
  task final_report;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // interrupt pulses, active cycles and hang guard
  always @(posedge mclk) begin
    if (irq === 1'b1) irqs++;
    if (act === 1'b1) actCyc++;
    cyc++;
    if (cyc == 8000) begin
      bad_count++;
      final_report;
    end
  end

  // ==========================================================
  // test sequence
  initial begin
    {mode, ac, gap, idxIn, srw, idxW, clr, req, we, addr, wd} = '0;
    rxLvl = 1'b1;
    ce = 1'b1;
    repeat (5) @(posedge mclk);
    #2 nrst = 1'b1;
    chk1(act, 1'b0); chk1(sOut, 1'b0); chk8({3'h0, idx}, 8'h00);
    // transmit/receive, first a start with the port off
    for (int i = 0; i < 3; i++) ram(1'b1, 5'(i), 8'h81 + 8'(i));
    idxIn = 5'h02; pulse(1);
    ac = 2'b10; mode = 2'b01;
    pulse(0); chk1(act, 1'b0);
    mode = 2'b11; pulse(0); chk1(act, 1'b1); chk1(inUse, 1'b1);
    waitIdle;
    chkGot('{8'h83, 8'h82, 8'h81});
    chk8({3'h0, idx}, 8'h00);
    chk1(flag, 1'b1); chk8(8'(irqs), 8'h01); chk1(sOut, 1'b0);
    for (int i = 0; i < 3; i++) begin
      ram(1'b0, 5'(i), 8'h00); chk8(rd, 8'hFF);
    end
    $display("test txrx done");
    // transmit-only, zeros on data-in must not land in the buffer
    rxLvl = 1'b0; ac = 2'b00; pulse(2); chk1(flag, 1'b0);
    for (int i = 0; i < 3; i++) ram(1'b1, 5'(i), 8'h81 + 8'(i));
    idxIn = 5'h02; pulse(1);
    actCyc = 0;
    pulse(0); chk1(inUse, 1'b0);
    waitIdle;
    chkGot('{8'h83, 8'h82, 8'h81}); chk1(flag, 1'b1);
    // two gaps of 64 clocks plus three bytes of about twenty clocks each
    chk1(actCyc >= 160 && actCyc <= 240, 1'b1);
    for (int i = 0; i < 3; i++) begin
      ram(1'b0, 5'(i), 8'h00); chk8(rd, 8'h81 + 8'(i));
    end
    $display("test txonly done");
    // repeat mode, port off in the gap before the fourth byte ends the run after that byte
    ac = 2'b01; pulse(2); idxIn = 5'h01; pulse(1); pulse(0);
    while (asb_serial_peer_i.got.size() < 3) @(posedge mclk);
    repeat (20) @(posedge mclk);
    #2 mode.serialPortOn = 1'b0;
    waitIdle;
    chkGot('{8'h82, 8'h81, 8'h82, 8'h81});
    chk1(flag, 1'b0); chk8(8'(irqs), 8'h02); chk1(sOut, 1'b0);
    chk8({3'h0, idx}, 8'h01);
    $display("test repeat done");
    // freeze: an index write while the clock enable is low must not land
    ce = 1'b0;
    idxIn = 5'h03;
    pulse(1);
    chk8({3'h0, idx}, 8'h01);
    ce = 1'b1;
    $display("test freeze done");
    final_report;
  end
endmodule

// File: verif/asb_serial_peer.sv
/*
  Serial peer model: makes the link clock during a run, drives a fixed
  level on data-in and frames the bytes seen on data-out.
  Assumes every byte sent has its top bit set, which marks its first bit.
*/
`timescale 1ns/10ps
module asb_serial_peer (
  // control from the bench
  input  wire logic run,
  input  wire logic rxLvl,
  // serial lines
  input  wire logic serialOut,
  output logic      sclk,
  output logic      serialIn
);
  logic [7:0] got[$];
  logic [7:0] sh;
  int         cnt = 0;
  // ==========================================================
  // link clock: stands still low outside a run
  initial sclk = 1'b0;
  always begin
    #32;
    if (run || sclk) sclk = ~sclk;
  end
  // a released data line shows the inverse level, not the last one
  assign serialIn = run ? rxLvl : ~rxLvl;
  // sample half a period after the device moves its output
  always @(negedge sclk) begin
    if (cnt != 0 || serialOut === 1'b1) begin
      sh = {sh[6:0], serialOut};
      cnt = cnt + 1;
      if (cnt == 8) begin
        got.push_back(sh);
        cnt = 0;
      end
    end
  end
endmodule
